// File: hw/mpm_pkg.sv
// Constants and types for the metering pin function mux
package mpm_pkg;
    // Clock output source select codes
    localparam logic [1:0] CLK_SEL_DSP     = 2'h0;
    localparam logic [1:0] CLK_SEL_CIC     = 2'h1;
    localparam logic [1:0] CLK_SEL_MOD     = 2'h2;
    localparam logic [1:0] CLK_SEL_MAIN    = 2'h3;
    // Clock/zero-cross pin function codes
    localparam logic [1:0] CZ_FN_CLOCK     = 2'h0;
    localparam logic [1:0] CZ_FN_ZC_VOLT   = 2'h1;
    localparam logic [1:0] CZ_FN_ZC_CURR   = 2'h2;
    localparam logic [1:0] CZ_FN_OFF       = 2'h3;
    // Energy type codes
    localparam logic [1:0] EN_ACTIVE       = 2'h0;
    localparam logic [1:0] EN_FUND_ACTIVE  = 2'h1;
    localparam logic [1:0] EN_REACTIVE     = 2'h2;
    localparam logic [1:0] EN_APPARENT     = 2'h3;
    // Channel source codes
    localparam logic [1:0] CH_PRIMARY      = 2'h0;
    localparam logic [1:0] CH_SECONDARY    = 2'h1;
    localparam logic [1:0] CH_SUM          = 2'h2;
    localparam logic [1:0] CH_DIFF         = 2'h3;
    // Timing
    localparam int CLK_FREQ_HZ             = 100_000_000;
    localparam int BITSTREAM_RATE_HZ       = 4_000_000;
    localparam int DECIMATION_FACTOR       = 512;
    localparam int BIT_PERIOD_CYCLES       = CLK_FREQ_HZ / BITSTREAM_RATE_HZ;
    localparam int PULSE_WIDTH_CYCLES      = 4;
    localparam int PULSE_CNT_W             = 3;
    localparam logic [PULSE_CNT_W-1:0] PULSE_WIDTH =
        PULSE_CNT_W'(PULSE_WIDTH_CYCLES);
    // Reset values
    localparam logic RESET_PORT_SPI        = 1'b1;
    localparam logic PIN_IDLE              = 1'b0;
    // Power-up strap sampler states
    typedef enum logic [2:0]
    {
        STRAP_WAIT   = 3'b001,
        STRAP_SAMPLE = 3'b010,
        STRAP_RUN    = 3'b100
    } mpm_strap_e;
endpackage

// File: hw/mpm_pulse_gen.sv
// Fixed-width energy pulse generator for one pulse output
`timescale 1ns/1ps
module mpm_pulse_gen
    import mpm_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       enable_in,
    input  wire logic [3:0] quantum_in,
    input  wire logic [1:0] source_sel_in,
    output logic            pulse_out
);
    logic                   busy;
    logic [PULSE_CNT_W-1:0] width_cnt;
    logic                   hit;

    always_comb
    begin
        hit = quantum_in[source_sel_in];
    end

    // One pulse of fixed width per quantum; quanta during a pulse merge
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            busy      <= 1'b0;
            width_cnt <= '0;
            pulse_out <= PIN_IDLE;
        end
        else if (enable_in)
        begin
            if (!busy && hit)
            begin
                busy      <= 1'b1;
                width_cnt <= PULSE_WIDTH - 1'b1;
                pulse_out <= 1'b1;
            end
            else if (busy && width_cnt == '0)
            begin
                busy      <= 1'b0;
                pulse_out <= 1'b0;
            end
            else if (busy)
            begin
                width_cnt <= width_cnt - 1'b1;
            end
        end
    end

    pulse_width_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(pulse_out) |-> $past(pulse_out, 4))
        else $error("pulse shorter than fixed width");
endmodule

// File: hw/mpm_skid_buf.sv
// Two-entry valid/ready buffer for a bitstream sample path
`timescale 1ns/1ps
module mpm_skid_buf
#(
    parameter int WIDTH = 4,
    parameter int DEPTH = 2
)
(
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic             enable_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW:0]      next_count;
    logic             do_wr;
    logic             do_rd;

    always_comb
    begin
        out_valid_out = (count != '0);
        out_data_out  = mem[rd_ptr];
        do_wr         = enable_in && in_valid_in && in_ready_out;
        do_rd         = enable_in && out_valid_out && out_ready_in;
        next_count    = count + (PW+1)'(do_wr) - (PW+1)'(do_rd);
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= '0;
        end
        else if (do_wr)
        begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            in_ready_out <= 1'b1;
        end
        else
        begin
            if (do_wr)
                wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            count <= next_count;
            // Registered ready keeps the upstream port flop-driven
            in_ready_out <= (next_count != (PW+1)'(DEPTH));
        end
    end

    no_overflow_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        count <= (PW+1)'(DEPTH))
        else $error("buffer count overflow");
endmodule

// File: hw/mpm_pin_mux.sv
// Multifunction pin selection for the metering front end
//
// Function
// - Clock function drives DSP, filter, modulator or main clock tap.
// - Zero-cross function signals voltage or current zero crossings.
// - Pulse mode selects energy type and channel, sum or difference.
// - Two independent pulse trains proportional to chosen power.
// - First pulse pin alternate: primary current bitstream.
// - Second pulse pin alternate: secondary current bitstream.
// - Two interrupt outputs with configurable trigger masks.
// - First interrupt pin alternate: primary voltage bitstream.
// - Second interrupt pin alternate: secondary voltage bitstream.
// - Port select strap sampled after reset, then used as chip select.
// - Serial input routed to SPI data in or UART receive.
// - Serial output driven from SPI data out or UART transmit.
// - Routed bitstreams are 4 MHz modulator streams.
`timescale 1ns/1ps
module mpm_pin_mux
    import mpm_pkg::*;
#(
    parameter int IRQ_SRC_W = 8
)
(
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 clk_en_in,
    // Internal sources
    input  wire logic [3:0]           clock_taps_in,
    input  wire logic                 zc_voltage_in,
    input  wire logic                 zc_current_in,
    input  wire logic [3:0]           energy_quantum_primary_in,
    input  wire logic [3:0]           energy_quantum_secondary_in,
    input  wire logic [3:0]           energy_quantum_sum_in,
    input  wire logic [3:0]           energy_quantum_diff_in,
    input  wire logic [IRQ_SRC_W-1:0] irq_events_in,
    input  wire logic                 bitstream_valid_in,
    input  wire logic [3:0]           bitstreams_in,
    output logic                      bitstream_ready_out,
    // Configuration fields
    input  wire logic [1:0]           cz_function_in,
    input  wire logic [1:0]           clock_select_in,
    input  wire logic [1:0]           pulse_energy_first_in,
    input  wire logic [1:0]           pulse_channel_first_in,
    input  wire logic                 pulse_alt_first_in,
    input  wire logic [1:0]           pulse_energy_second_in,
    input  wire logic [1:0]           pulse_channel_second_in,
    input  wire logic                 pulse_alt_second_in,
    input  wire logic [IRQ_SRC_W-1:0] irq_mask_first_in,
    input  wire logic                 irq_alt_first_in,
    input  wire logic [IRQ_SRC_W-1:0] irq_mask_second_in,
    input  wire logic                 irq_alt_second_in,
    // Serial port core side
    input  wire logic                 spi_data_out_in,
    input  wire logic                 uart_tx_in,
    output logic                      spi_data_in_out,
    output logic                      uart_rx_out,
    output logic                      chip_select_n_out,
    output logic                      port_is_spi_out,
    // Pins
    input  wire logic                 port_select_chip_select_in,
    input  wire logic                 serial_in_pin_in,
    output logic                      serial_out_pin_out,
    output logic                      clock_or_zero_cross_pin_out,
    output logic                      pulse_out_first_out,
    output logic                      pulse_out_second_out,
    output logic                      irq_out_first_out,
    output logic                      irq_out_second_out
);
    import mpm_pkg::*;

    logic [1:0]  cs_sync;
    logic [1:0]  rx_sync;
    logic [1:0]  zv_sync;
    logic [1:0]  zi_sync;
    logic        zv_prev;
    logic        zi_prev;
    mpm_strap_e  strap_state;
    logic        port_spi;
    logic [3:0]  bit_hold;
    logic        bit_valid;
    logic [3:0]  bit_data;
    logic [$clog2(BIT_PERIOD_CYCLES)-1:0] bit_cnt;
    logic        bit_tick;
    logic [3:0]  quanta_first;
    logic [3:0]  quanta_second;
    logic        pulse_first;
    logic        pulse_second;
    logic        next_cz;

    // Picks the 4-bit quantum group for a channel source code
    function automatic logic [3:0] pick_channel(input logic [1:0] sel,
        input logic [3:0] p, input logic [3:0] s,
        input logic [3:0] a, input logic [3:0] d);
        case (sel)
            CH_PRIMARY:   pick_channel = p;
            CH_SECONDARY: pick_channel = s;
            CH_SUM:       pick_channel = a;
            default:      pick_channel = d;
        endcase
    endfunction

    // Pin inputs pass two flip-flops
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cs_sync <= 2'h3;
            rx_sync <= 2'h3;
            zv_sync <= 2'h0;
            zi_sync <= 2'h0;
            zv_prev <= 1'b0;
            zi_prev <= 1'b0;
        end
        else if (clk_en_in)
        begin
            cs_sync <= {cs_sync[0], port_select_chip_select_in};
            rx_sync <= {rx_sync[0], serial_in_pin_in};
            zv_sync <= {zv_sync[0], zc_voltage_in};
            zi_sync <= {zi_sync[0], zc_current_in};
            zv_prev <= zv_sync[1];
            zi_prev <= zi_sync[1];
        end
    end

    // Strap sampled once after reset release, pin then serves as select
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            strap_state <= STRAP_WAIT;
            port_spi    <= RESET_PORT_SPI;
        end
        else if (clk_en_in)
        begin
            case (strap_state)
                // Lets the synchroniser flush its reset value first
                STRAP_WAIT:
                    if (bit_cnt != '0)
                        strap_state <= STRAP_SAMPLE;
                STRAP_SAMPLE:
                begin
                    port_spi    <= cs_sync[1];
                    strap_state <= STRAP_RUN;
                end
                STRAP_RUN:    strap_state <= STRAP_RUN;
                default:      strap_state <= STRAP_WAIT;
            endcase
        end
    end

    // Serial routing by sampled port selection
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            spi_data_in_out    <= 1'b0;
            uart_rx_out        <= 1'b1;
            serial_out_pin_out <= 1'b1;
            chip_select_n_out  <= 1'b1;
            port_is_spi_out    <= RESET_PORT_SPI;
        end
        else if (clk_en_in)
        begin
            port_is_spi_out    <= port_spi;
            chip_select_n_out  <= (strap_state == STRAP_RUN) ?
                                  cs_sync[1] : 1'b1;
            spi_data_in_out    <= port_spi ? rx_sync[1] : 1'b0;
            uart_rx_out        <= port_spi ? 1'b1 : rx_sync[1];
            serial_out_pin_out <= port_spi ? spi_data_out_in
                                           : uart_tx_in;
        end
    end

    // Modulator bit clock: one sample per 4 MHz bit period
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            bit_cnt <= '0;
        else if (clk_en_in)
            bit_cnt <= (bit_cnt == ($clog2(BIT_PERIOD_CYCLES))'(
                BIT_PERIOD_CYCLES - 1)) ? '0 : bit_cnt + 1'b1;
    end

    always_comb
    begin
        bit_tick = (bit_cnt == '0);
    end

    mpm_skid_buf #(.WIDTH(4), .DEPTH(2)) u_buf
    (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .enable_in     (clk_en_in),
        .in_valid_in   (bitstream_valid_in),
        .in_ready_out  (bitstream_ready_out),
        .in_data_in    (bitstreams_in),
        .out_valid_out (bit_valid),
        .out_ready_in  (bit_tick),
        .out_data_out  (bit_data)
    );

    // Bits are held on the pins for a whole bit period
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            bit_hold <= 4'h0;
        else if (clk_en_in && bit_tick && bit_valid)
            bit_hold <= bit_data;
    end

    always_comb
    begin
        quanta_first  = pick_channel(pulse_channel_first_in,
            energy_quantum_primary_in, energy_quantum_secondary_in,
            energy_quantum_sum_in, energy_quantum_diff_in);
        quanta_second = pick_channel(pulse_channel_second_in,
            energy_quantum_primary_in, energy_quantum_secondary_in,
            energy_quantum_sum_in, energy_quantum_diff_in);
    end

    mpm_pulse_gen u_pulse_first
    (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .enable_in     (clk_en_in),
        .quantum_in    (quanta_first),
        .source_sel_in (pulse_energy_first_in),
        .pulse_out     (pulse_first)
    );

    mpm_pulse_gen u_pulse_second
    (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .enable_in     (clk_en_in),
        .quantum_in    (quanta_second),
        .source_sel_in (pulse_energy_second_in),
        .pulse_out     (pulse_second)
    );

    always_comb
    begin
        case (cz_function_in)
            CZ_FN_CLOCK:   next_cz = clock_taps_in[clock_select_in];
            CZ_FN_ZC_VOLT: next_cz = zv_sync[1] ^ zv_prev;
            CZ_FN_ZC_CURR: next_cz = zi_sync[1] ^ zi_prev;
            default:       next_cz = PIN_IDLE;
        endcase
    end

    // Each pin registers exactly one selected function
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            clock_or_zero_cross_pin_out <= PIN_IDLE;
            pulse_out_first_out         <= PIN_IDLE;
            pulse_out_second_out        <= PIN_IDLE;
            irq_out_first_out           <= PIN_IDLE;
            irq_out_second_out          <= PIN_IDLE;
        end
        else if (clk_en_in)
        begin
            clock_or_zero_cross_pin_out <= next_cz;
            pulse_out_first_out  <= pulse_alt_first_in ?
                                    bit_hold[0] : pulse_first;
            pulse_out_second_out <= pulse_alt_second_in ?
                                    bit_hold[1] : pulse_second;
            irq_out_first_out    <= irq_alt_first_in ? bit_hold[2] :
                |(irq_events_in & irq_mask_first_in);
            irq_out_second_out   <= irq_alt_second_in ? bit_hold[3] :
                |(irq_events_in & irq_mask_second_in);
        end
    end

    pulse_route_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        clk_en_in && !pulse_alt_first_in |=> pulse_out_first_out ==
        $past(pulse_first))
        else $error("first pulse pin not routed");
    bit_first_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && pulse_alt_first_in |=> pulse_out_first_out ==
        $past(bit_hold[0]))
        else $error("first current bitstream not routed");
    bit_second_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && pulse_alt_second_in |=> pulse_out_second_out ==
        $past(bit_hold[1]))
        else $error("second current bitstream not routed");
    irq_first_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && !irq_alt_first_in |=> irq_out_first_out ==
        $past(|(irq_events_in & irq_mask_first_in)))
        else $error("first interrupt wrong");
    volt_first_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && irq_alt_first_in |=> irq_out_first_out ==
        $past(bit_hold[2]))
        else $error("primary voltage bitstream not routed");
    volt_second_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        clk_en_in && irq_alt_second_in |=> irq_out_second_out ==
        $past(bit_hold[3]))
        else $error("secondary voltage bitstream not routed");
    clock_sel_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && cz_function_in == CZ_FN_CLOCK |=>
        clock_or_zero_cross_pin_out == $past(clock_taps_in[clock_select_in]))
        else $error("clock tap not routed");
    serial_out_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        clk_en_in |=> serial_out_pin_out == ($past(port_spi) ?
        $past(spi_data_out_in) : $past(uart_tx_in)))
        else $error("serial output wrong");
    strap_hold_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        strap_state == STRAP_RUN |=> $stable(port_spi))
        else $error("port selection changed after power-up");
    bit_rate_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && bit_tick |=> !bit_tick)
        else $error("bit clock too fast");
endmodule

// File: tb/mpm_host_model.sv
// Host controller model: strap, chip select and serial line
`timescale 1ns/1ps
module mpm_host_model
(
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic strap_spi_in,
    input  wire logic select_in,
    input  wire logic tx_bit_in,
    output logic      cs_pin_out,
    output logic      line_out
);
    logic [2:0] hold;
    logic       last_line;
    // Keep the strap well past the device's sampling window
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            hold <= 3'h0;
        else if (hold != 3'h7)
            hold <= hold + 3'h1;
    end
    // Strap level first, then active-low select of the serial port
    assign cs_pin_out = (hold != 3'h7) ? strap_spi_in : !select_in;
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            last_line <= 1'b0;
        else
            last_line <= line_out;
    end
    // A released line toggles, so a stale bit is never seen as valid
    assign line_out = select_in ? tx_bit_in : !last_line;
endmodule

// File: tb/testbench.sv
// Self-checking bench for the metering pin function mux
`timescale 1ns/1ps
module testbench;
    import mpm_pkg::*;
    logic clk_in = 1'b0, reset_n_in = 1'b0, clk_en_in = 1'b1;
    logic zc_voltage_in = 1'b0, zc_current_in = 1'b0;
    logic bitstream_valid_in = 1'b0, spi_data_out_in = 1'b0;
    logic uart_tx_in = 1'b1, strap = 1'b1, sel = 1'b0, tx_bit = 1'b0;
    logic pulse_alt_first_in = 1'b0, pulse_alt_second_in = 1'b0;
    logic irq_alt_first_in = 1'b0, irq_alt_second_in = 1'b0;
    logic [3:0] clock_taps_in = '0, bitstreams_in = '0, w, e;
    logic [3:0][3:0] quanta = '0;
    logic [7:0] irq_events_in = '0, irq_mask_first_in = '0;
    logic [7:0] irq_mask_second_in = '0;
    logic [1:0] cz_function_in = CZ_FN_OFF, clock_select_in = '0;
    logic [1:0] pulse_energy_first_in = '0, pulse_channel_first_in = '0;
    logic [1:0] pulse_energy_second_in = '0, pulse_channel_second_in = '0;
    logic bitstream_ready_out, spi_data_in_out, uart_rx_out;
    logic chip_select_n_out, port_is_spi_out, serial_out_pin_out;
    logic clock_or_zero_cross_pin_out, pulse_out_first_out;
    logic pulse_out_second_out, irq_out_first_out, irq_out_second_out;
    logic port_select_chip_select_in, serial_in_pin_in;
    logic [2:0] watch = '0;
    logic watch_bs = 1'b0, refused = 1'b0;
    logic [3:0] bs_last, exp_bs [$];
    int exp_w [3][$];
    int width [3] = '{0, 0, 0};
    int gap = 0, failures = 0, tests_run = 0;

    mpm_pin_mux dut_u
    (
        .clk_in, .reset_n_in, .clk_en_in, .clock_taps_in,
        .zc_voltage_in, .zc_current_in,
        .energy_quantum_primary_in(quanta[0]),
        .energy_quantum_secondary_in(quanta[1]),
        .energy_quantum_sum_in(quanta[2]),
        .energy_quantum_diff_in(quanta[3]),
        .irq_events_in, .bitstream_valid_in, .bitstreams_in,
        .bitstream_ready_out, .cz_function_in, .clock_select_in,
        .pulse_energy_first_in, .pulse_channel_first_in,
        .pulse_alt_first_in, .pulse_energy_second_in,
        .pulse_channel_second_in, .pulse_alt_second_in,
        .irq_mask_first_in, .irq_alt_first_in, .irq_mask_second_in,
        .irq_alt_second_in, .spi_data_out_in, .uart_tx_in,
        .spi_data_in_out, .uart_rx_out, .chip_select_n_out,
        .port_is_spi_out, .port_select_chip_select_in, .serial_in_pin_in,
        .serial_out_pin_out, .clock_or_zero_cross_pin_out,
        .pulse_out_first_out, .pulse_out_second_out,
        .irq_out_first_out, .irq_out_second_out
    );

    mpm_host_model host_u
    (
        .clk_in, .reset_n_in, .strap_spi_in(strap), .select_in(sel),
        .tx_bit_in(tx_bit), .cs_pin_out(port_select_chip_select_in),
        .line_out(serial_in_pin_in)
    );

    initial
        forever #5 clk_in = ~clk_in;

    task automatic check_level(input logic [3:0] ex, input logic [3:0] got);
        tests_run++;
        if (got !== ex)
        begin
            failures++;
            $display("[ERR] %0t level got %h exp %h", $time, got, ex);
        end
    endtask

    task automatic check_width(input int ex, input int got);
        tests_run++;
        if (got != ex)
        begin
            failures++;
            $display("[ERR] %0t count got %0d exp %0d", $time, got, ex);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic do_reset(input logic s);
        strap <= s;
        reset_n_in <= 1'b0;
        tick(8);
        check_level(4'hf, {serial_out_pin_out, uart_rx_out,
            chip_select_n_out, port_is_spi_out});
        check_level(4'h0, {clock_or_zero_cross_pin_out,
            pulse_out_first_out, irq_out_first_out, irq_out_second_out});
        reset_n_in <= 1'b1;
        tick(12);
        check_level({3'h0, s}, {3'h0, port_is_spi_out});
    endtask

    // Drive one quantum pulse; m marks which pulse pins should answer
    task automatic fire(input logic [1:0] ch, en, m, input int after);
        quanta <= 16'h1 << {ch, en};
        if (m[0])
            exp_w[0].push_back(PULSE_WIDTH_CYCLES);
        if (m[1])
            exp_w[1].push_back(PULSE_WIDTH_CYCLES);
        tick(1);
        quanta <= '0;
        tick(after);
    endtask

    task automatic push(input logic [3:0] d);
        logic rdy;
        rdy = 1'b0;
        bitstream_valid_in <= 1'b1;
        bitstreams_in <= d;
        for (int n = 0; n < 100 && rdy !== 1'b1; n++)
        begin
            @(negedge clk_in);
            rdy = bitstream_ready_out;
            refused |= (rdy !== 1'b1);
            @(posedge clk_in);
        end
        if (rdy !== 1'b1)
        begin
            check_width(1, 0);
            report_and_stop();
        end
    endtask

    task automatic serial_check(input logic spi);
        for (int k = 0; k < 8; k++)
        begin
            sel <= k[0];
            tx_bit <= 1'($urandom);
            spi_data_out_in <= 1'($urandom);
            uart_tx_in <= 1'($urandom);
            tick(6);
            e = {1'b0, !sel, spi ? spi_data_out_in : uart_tx_in, sel & tx_bit};
            w = {1'b0, chip_select_n_out, serial_out_pin_out,
                 sel & (spi ? spi_data_in_out : uart_rx_out)};
            check_level(e, w);
        end
    endtask

    // Pulse widths on the two pulse pins and the clock/zero-cross pin, bitstream words on four pins
    always @(negedge clk_in)
    begin
        logic [2:0] pins;
        logic [3:0] now4;
        pins = {clock_or_zero_cross_pin_out, pulse_out_second_out,
                pulse_out_first_out};
        now4 = {irq_out_second_out, irq_out_first_out, pins[1:0]};
        for (int i = 0; i < 3; i++)
        begin
            if (!watch[i])
                width[i] = 0;
            else if (pins[i] === 1'b1)
                width[i]++;
            else if (width[i] > 0)
            begin
                check_width(exp_w[i].size() ? exp_w[i].pop_front() : 0,
                    width[i]);
                width[i] = 0;
            end
        end
        gap++;
        if (watch_bs && now4[0] !== bs_last[0])
        begin
            check_width(1, gap >= BIT_PERIOD_CYCLES);
            check_level(exp_bs.size() ? exp_bs.pop_front() : 4'hx, now4);
            gap = 0;
        end
        if (!watch_bs)
            gap = BIT_PERIOD_CYCLES;
        bs_last = now4;
    end

    initial
    begin
        void'($urandom(32'hd25dc3b6));
        do_reset(1'b1);
        cz_function_in <= CZ_FN_CLOCK;
        for (int s = 0; s < 16; s++)
        begin
            clock_select_in <= s[1:0];
            clock_taps_in <= 4'($urandom);
            tick(4);
            check_level({3'h0, clock_taps_in[s[1:0]]},
                {3'h0, clock_or_zero_cross_pin_out});
        end
        cz_function_in <= CZ_FN_OFF;
        tick(4);
        watch <= 3'h4;
        for (int f = 1; f < 3; f++)
        begin
            cz_function_in <= (f == 1) ? CZ_FN_ZC_VOLT : CZ_FN_ZC_CURR;
            tick(4);
            for (int k = 0; k < 2; k++)
            begin
                zc_voltage_in <= !zc_voltage_in;
                if (f == 1)
                    exp_w[2].push_back(1);
                tick(8);
                zc_current_in <= !zc_current_in;
                if (f == 2)
                    exp_w[2].push_back(1);
                tick(8);
            end
        end
        watch <= 3'h7;
        for (int c = 0; c < 16; c++)
        begin
            pulse_energy_first_in <= c[1:0];
            pulse_energy_second_in <= c[1:0];
            pulse_channel_first_in <= c[3:2];
            pulse_channel_second_in <= c[3:2] ^ 2'h1;
            tick(3);
            fire(c[3:2], c[1:0], 2'h1, 10);
            fire(c[3:2] ^ 2'h1, c[1:0], 2'h2, 10);
            fire(c[3:2], c[1:0] ^ 2'h2, 2'h0, 10);
        end
        fire(2'h3, 2'h3, 2'h1, 1);
        fire(2'h3, 2'h3, 2'h0, 10);
        watch <= 3'h0;
        for (int i = 0; i < 3; i++)
            check_width(0, exp_w[i].size());
        for (int k = 0; k < 12; k++)
        begin
            irq_mask_first_in <= 8'($urandom);
            irq_mask_second_in <= 8'($urandom);
            irq_events_in <= k[0] ? 8'h0 : 8'($urandom);
            tick(4);
            e = {2'h0, |(irq_events_in & irq_mask_second_in),
                 |(irq_events_in & irq_mask_first_in)};
            check_level(e, {2'h0, irq_out_second_out, irq_out_first_out});
        end
        serial_check(1'b1);
        {pulse_alt_first_in, pulse_alt_second_in} <= 2'h3;
        {irq_alt_first_in, irq_alt_second_in} <= 2'h3;
        tick(4);
        w = {3'h0, pulse_out_first_out};
        watch_bs <= 1'b1;
        for (int k = 0; k < 12; k++)
        begin
            w = {3'($urandom), !w[0]};
            exp_bs.push_back(w);
            push(w);
        end
        bitstream_valid_in <= 1'b0;
        check_level(4'h1, {3'h0, refused});
        for (int n = 0; n < 400 && exp_bs.size() > 0; n++)
            tick(1);
        check_width(0, exp_bs.size());
        if (exp_bs.size() > 0)
            report_and_stop();
        watch_bs <= 1'b0;
        do_reset(1'b0);
        serial_check(1'b0);
        report_and_stop();
    end
endmodule
